// ==== rtl/shs_homing.sv ====
// Homing sequencer for a single-axis servo controller.
`timescale 1ns/1ps
module shs_homing #(
  parameter int CYC_PER_MS = shs_pkg::SHS_CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic auto_manual_select,
  input wire logic program_select_input,
  input wire logic start,
  input wire logic servo_on,
  input wire logic [3:0] method,
  input wire logic direction,
  input wire logic dog_polarity,
  input wire logic dog_shorted,
  input wire logic z_pulse,
  input wire logic stopper_contact,
  input wire logic motor_2000rpm,
  input wire logic [shs_pkg::SHS_POS_W-1:0] current_position,
  input wire logic [shs_pkg::SHS_SPD_W-1:0] zeroing_speed,
  input wire logic [shs_pkg::SHS_SPD_W-1:0] creep_speed,
  input wire logic [shs_pkg::SHS_POS_W-1:0] zero_shift,
  input wire logic [shs_pkg::SHS_POS_W-1:0] count_distance,
  input wire logic [15:0] stopper_time_ms,
  input wire logic [15:0] stopper_torque,
  input wire logic [15:0] accel_tc_pt1,
  input wire logic [15:0] decel_tc_pt1,
  output logic [shs_pkg::SHS_SPD_W-1:0] speed_cmd,
  output logic move_enable,
  output logic move_decrease,
  output logic [15:0] accel_tc_out,
  output logic [15:0] decel_tc_out,
  output logic torque_limit_on,
  output logic [15:0] torque_limit_out,
  output logic [shs_pkg::SHS_POS_W-1:0] zero_position_data,
  output logic zero_position_write,
  output logic zeroing_complete,
  output logic zeroing_busy,
  output logic method_error,
  output logic [shs_pkg::SHS_REV_W-1:0] within_rev_pos,
  output logic [shs_pkg::SHS_REV_W-1:0] mid_rev_ref
);
  import shs_pkg::*;

  // ---------------------------------------------------------------
  // Decoding and helpers
  // ---------------------------------------------------------------
  function automatic logic shs_is_dog_method(input logic [3:0] m);
    shs_is_dog_method = (m == SHS_METHOD_DOG) || (m == SHS_METHOD_COUNT);
  endfunction

  function automatic logic [SHS_POS_W-1:0] shs_abs_diff(
    input logic [SHS_POS_W-1:0] a,
    input logic [SHS_POS_W-1:0] b
  );
    logic [SHS_POS_W-1:0] d;
    d = a - b;
    shs_abs_diff = d[SHS_POS_W-1] ? (~d + 32'h0000_0001) : d;
  endfunction

  shs_state_type state_reg, state_next;
  logic [SHS_POS_W-1:0] mark_reg, mark_next;
  logic [SHS_POS_W-1:0] home_reg, home_next;
  logic [SHS_POS_W-1:0] zpos_reg, zpos_next;
  logic [15:0] dwell_reg, dwell_next;
  logic [31:0] ms_cnt_reg, ms_cnt_next;
  logic done_reg, done_next;
  logic wr_reg, wr_next;
  logic err_reg, err_next;
  logic dog_prev_reg, dog_prev_next;
  logic son_prev_reg, son_prev_next;
  logic [3:0] meth_reg, meth_next;
  logic dir_reg, dir_next;
  logic dog_active;
  logic dog_rise;
  logic dog_fall;
  logic son_rise;
  logic manual_mode;
  logic ms_tick;
  logic [SHS_POS_W-1:0] travelled;
  logic [SHS_POS_W-1:0] rev_delta;

  assign dog_active = dog_polarity ? dog_shorted : ~dog_shorted;
  assign dog_rise = dog_active & ~dog_prev_reg;
  assign dog_fall = ~dog_active & dog_prev_reg;
  assign son_rise = servo_on & ~son_prev_reg;
  // The outside party owns these two levels; a run aborts if auto_manual_select rises or program_select_input drops.
  assign manual_mode = ~auto_manual_select & program_select_input;
  assign travelled = shs_abs_diff(current_position, mark_reg);
  assign ms_tick = (ms_cnt_reg == 32'(CYC_PER_MS - 1));
  // Measuring from the next capture makes the reading zero in the Z cycle.
  assign rev_delta = current_position - zpos_next;

  // ---------------------------------------------------------------
  // Millisecond divider for the stopper dwell
  // ---------------------------------------------------------------
  always_comb begin
    ms_cnt_next = ms_cnt_reg + 32'h0000_0001;
    if (state_reg != SHS_STOPPER || !stopper_contact || ms_tick) begin
      ms_cnt_next = 32'h0000_0000;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ms_cnt_reg <= 32'h0000_0000;
    end else begin
      ms_cnt_reg <= ms_cnt_next;
    end
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    mark_next = mark_reg;
    home_next = home_reg;
    dwell_next = dwell_reg;
    done_next = done_reg;
    wr_next = 1'b0;
    err_next = err_reg;
    meth_next = meth_reg;
    dir_next = dir_reg;
    dog_prev_next = dog_active;
    son_prev_next = servo_on;
    zpos_next = z_pulse ? current_position : zpos_reg;
    unique case (state_reg)
      SHS_IDLE: begin
        if (manual_mode && start) begin
          meth_next = method;
          dir_next = direction;
          done_next = 1'b0;
          err_next = 1'b0;
          mark_next = current_position;
          unique case (method)
            SHS_METHOD_DOG, SHS_METHOD_COUNT: begin
              state_next = SHS_FAST;
            end
            SHS_METHOD_DATA: begin
              home_next = current_position;
              state_next = SHS_DONE;
            end
            SHS_METHOD_STOPPER: begin
              dwell_next = SHS_MS_RESET;
              state_next = SHS_STOPPER;
            end
            SHS_METHOD_SERVO_ON: begin
              done_next = done_reg;
            end
            default: begin
              err_next = 1'b1;
            end
          endcase
        end
        // Servo-on home needs no start and no motion.
        if (son_rise && method == SHS_METHOD_SERVO_ON) begin
          home_next = current_position;
          meth_next = method;
          err_next = 1'b0;
          state_next = SHS_DONE;
        end
      end
      SHS_FAST: begin
        if (dog_rise) begin
          mark_next = current_position;
          // Count type reacts at the front edge, so any dog length works.
          state_next = (meth_reg == SHS_METHOD_COUNT) ?
                       SHS_COUNT_MOVE : SHS_CREEP_DOG;
        end
      end
      SHS_CREEP_DOG: begin
        if (dog_fall) begin
          state_next = SHS_WAIT_Z;
        end
      end
      SHS_COUNT_MOVE: begin
        if (travelled >= count_distance) begin
          state_next = SHS_WAIT_Z;
        end
      end
      SHS_WAIT_Z: begin
        if (z_pulse) begin
          mark_next = current_position;
          if (zero_shift == SHS_POS_RESET) begin
            home_next = current_position;
            state_next = SHS_DONE;
          end else begin
            state_next = SHS_SHIFT;
          end
        end
      end
      SHS_SHIFT: begin
        if (travelled >= zero_shift) begin
          home_next = current_position;
          state_next = SHS_DONE;
        end
      end
      SHS_STOPPER: begin
        if (!stopper_contact) begin
          dwell_next = SHS_MS_RESET;
        end else if (dwell_reg >= stopper_time_ms) begin
          home_next = current_position;
          state_next = SHS_DONE;
        end else if (ms_tick) begin
          dwell_next = dwell_reg + 16'h0001;
        end
      end
      SHS_DONE: begin
        wr_next = 1'b1;
        done_next = 1'b1;
        state_next = SHS_IDLE;
      end
    endcase
    if (!manual_mode && state_reg != SHS_IDLE && state_reg != SHS_DONE) begin
      state_next = SHS_IDLE;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= SHS_IDLE;
      mark_reg <= SHS_POS_RESET;
      home_reg <= SHS_POS_RESET;
      zpos_reg <= SHS_POS_RESET;
      dwell_reg <= SHS_MS_RESET;
      done_reg <= 1'b0;
      wr_reg <= 1'b0;
      err_reg <= 1'b0;
      meth_reg <= SHS_METHOD_DOG;
      dir_reg <= 1'b0;
      dog_prev_reg <= 1'b0;
      son_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mark_reg <= mark_next;
      home_reg <= home_next;
      zpos_reg <= zpos_next;
      dwell_reg <= dwell_next;
      done_reg <= done_next;
      wr_reg <= wr_next;
      err_reg <= err_next;
      meth_reg <= meth_next;
      dir_reg <= dir_next;
      dog_prev_reg <= dog_prev_next;
      son_prev_reg <= son_prev_next;
    end
  end

  // ---------------------------------------------------------------
  // Motion and status outputs
  // ---------------------------------------------------------------
  always_comb begin
    speed_cmd = '0;
    move_enable = 1'b0;
    unique case (state_reg)
      SHS_FAST: begin
        speed_cmd = zeroing_speed;
        move_enable = 1'b1;
      end
      SHS_CREEP_DOG, SHS_COUNT_MOVE, SHS_WAIT_Z, SHS_SHIFT: begin
        speed_cmd = creep_speed;
        move_enable = 1'b1;
      end
      default: begin
        speed_cmd = '0;
      end
    endcase
  end

  // Stopper motion is jogged from outside; only the acceleration constant and torque are set.
  assign move_decrease = dir_reg;
  assign torque_limit_on = (state_reg == SHS_STOPPER);
  assign torque_limit_out = torque_limit_on ? stopper_torque : 16'h0000;
  assign accel_tc_out = (shs_is_dog_method(meth_reg) || torque_limit_on) ?
                        accel_tc_pt1 : 16'h0000;
  assign decel_tc_out = shs_is_dog_method(meth_reg) ?
                        decel_tc_pt1 : 16'h0000;
  assign zero_position_data = home_reg;
  assign zero_position_write = wr_reg;
  assign zeroing_complete = done_reg;
  assign zeroing_busy = (state_reg != SHS_IDLE);
  assign method_error = err_reg;
  assign within_rev_pos = rev_delta[SHS_REV_W-1:0];
  assign mid_rev_ref = motor_2000rpm ? SHS_MID_REV_2000 : SHS_MID_REV_3000;

endmodule // shs_homing

// ==== common/shs_pkg.sv ====
// Constants and types shared by the servo homing sequencer.
package shs_pkg;

  // ---------------------------------------------------------------
  // Zeroing method codes
  // ---------------------------------------------------------------
  localparam logic [3:0] SHS_METHOD_DOG = 4'h0;
  localparam logic [3:0] SHS_METHOD_COUNT = 4'h1;
  localparam logic [3:0] SHS_METHOD_DATA = 4'h2;
  localparam logic [3:0] SHS_METHOD_STOPPER = 4'h3;
  localparam logic [3:0] SHS_METHOD_SERVO_ON = 4'h4;

  // ---------------------------------------------------------------
  // Field widths and reset values
  // ---------------------------------------------------------------
  localparam int SHS_POS_W = 32;
  localparam int SHS_SPD_W = 16;
  localparam int SHS_REV_W = 14;
  localparam logic [31:0] SHS_POS_RESET = 32'h0000_0000;
  localparam logic [15:0] SHS_MS_RESET = 16'h0000;
  localparam logic [13:0] SHS_MID_REV_3000 = 14'h1000;
  localparam logic [13:0] SHS_MID_REV_2000 = 14'h2000;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int SHS_CLK_PERIOD_NS = 10;
  localparam int SHS_MS_NS = 1000000;
  localparam int SHS_DOG_MIN_MS = 10;
  localparam int SHS_CYC_PER_MS = SHS_MS_NS / SHS_CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    SHS_IDLE,
    SHS_FAST,
    SHS_CREEP_DOG,
    SHS_COUNT_MOVE,
    SHS_WAIT_Z,
    SHS_SHIFT,
    SHS_STOPPER,
    SHS_DONE
  } shs_state_type;

endpackage

// ==== testbench/shs_axis_model.sv ====
// Axis model: position counter, proximity dog and Z-phase marker.
`timescale 1ns/1ps
module shs_axis_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic move_enable,
  input wire logic move_decrease,
  input wire logic dog_polarity,
  input wire logic load,
  input wire logic [31:0] load_pos,
  output logic [31:0] current_position,
  output logic dog_shorted,
  output logic z_pulse
);
  logic [31:0] nxt;
  logic on_dog;
  // At one count a cycle the dog lasts 200 cycles, past the 10 ms floor.
  assign on_dog = current_position >= 32'hc8
    && current_position < 32'h190;
  assign dog_shorted = on_dog ? dog_polarity : !dog_polarity;
  assign nxt = move_decrease ? current_position - 32'h1
    : current_position + 32'h1;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      current_position <= 32'h0;
      z_pulse <= 1'b0;
    end else begin
      current_position <= load ? load_pos
        : (move_enable ? nxt : current_position);
      z_pulse <= move_enable && !load && nxt[5:0] == 6'h0;
    end
  end
endmodule // shs_axis_model

// ==== testbench/shs_homing_chk.sv ====
// Port-level assertions for the servo homing sequencer.
`timescale 1ns/1ps
module shs_homing_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic auto_manual_select,
  input wire logic program_select_input,
  input wire logic start,
  input wire logic servo_on,
  input wire logic [3:0] method,
  input wire logic dog_polarity,
  input wire logic dog_shorted,
  input wire logic motor_2000rpm,
  input wire logic [31:0] current_position,
  input wire logic [15:0] zeroing_speed,
  input wire logic [15:0] creep_speed,
  input wire logic [15:0] stopper_torque,
  input wire logic [15:0] accel_tc_pt1,
  input wire logic [15:0] decel_tc_pt1,
  input wire logic [15:0] speed_cmd,
  input wire logic move_enable,
  input wire logic [15:0] accel_tc_out,
  input wire logic [15:0] decel_tc_out,
  input wire logic torque_limit_on,
  input wire logic [15:0] torque_limit_out,
  input wire logic [31:0] zero_position_data,
  input wire logic zero_position_write,
  input wire logic zeroing_busy,
  input wire logic method_error,
  input wire logic [13:0] mid_rev_ref
);
  logic take;
  logic dog_act;
  assign take = start && !zeroing_busy && !auto_manual_select
    && program_select_input;
  assign dog_act = dog_shorted == dog_polarity;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_write_pulse: assert property (zero_position_write |=>
    !zero_position_write) else $error("store pulse too long");
  a_mid_ref: assert property ($stable(motor_2000rpm) && !$past(rst) |->
    mid_rev_ref == (motor_2000rpm ? 14'h2000 : 14'h1000))
    else $error("mid revolution reference wrong");
  a_data_home: assert property (take && method == 4'h2 |-> ##2
    zero_position_write && zero_position_data == $past(current_position, 2))
    else $error("data setting home wrong");
  a_servo_home: assert property (!zeroing_busy && $rose(servo_on)
    && method == 4'h4 |=> !move_enable ##1 zero_position_write
    && zero_position_data == $past(current_position, 2))
    else $error("servo-on home wrong");
  a_bad_method: assert property (take && method > 4'h4 |=>
    method_error && !zeroing_busy) else $error("bad method accepted");
  a_dog_creep: assert property (move_enable && speed_cmd == zeroing_speed
    && dog_act && !$past(dog_act) |-> ##[1:2] speed_cmd == creep_speed)
    else $error("no creep after dog");
  a_ramp_tc: assert property (move_enable && !torque_limit_on |->
    accel_tc_out == accel_tc_pt1 && decel_tc_out == decel_tc_pt1)
    else $error("ramp constants wrong");
  a_stop_torque: assert property (take && method == 4'h3 |=>
    torque_limit_on && torque_limit_out == stopper_torque
    && accel_tc_out == accel_tc_pt1) else $error("stopper limit wrong");
  cover property (take && method == 4'h1);
  cover property (zero_position_write && method == 4'h3);
  cover property (method_error);
endmodule // shs_homing_chk

// ==== testbench/shs_homing_test.sv ====
// Self-checking testbench for the servo homing sequencer.
`timescale 1ns/1ps
module shs_homing_test;
  import shs_pkg::*;
  logic core_clk = 1'b0, rst = 1'b1, auto_manual_select = 1'b0, load = 1'b0;
  logic program_select_input = 1'b1, start = 1'b0, servo_on = 1'b0;
  logic direction = 1'b0, dog_polarity = 1'b0, stopper_contact = 1'b0;
  logic motor_2000rpm = 1'b0, dog_shorted, z_pulse, move_enable;
  logic move_decrease, torque_limit_on, zero_position_write;
  logic zeroing_complete, zeroing_busy, method_error;
  logic [3:0] method = 4'h0;
  logic [31:0] zero_shift = 32'h0, count_distance = 32'h64, load_pos = 32'h0;
  logic [31:0] current_position, zero_position_data;
  logic [15:0] zeroing_speed = 16'h40, creep_speed = 16'h8;
  logic [15:0] stopper_time_ms = 16'h2, stopper_torque = 16'h3c;
  logic [15:0] accel_tc_pt1 = 16'h11, decel_tc_pt1 = 16'h22;
  logic [15:0] speed_cmd, accel_tc_out, decel_tc_out, torque_limit_out;
  logic [13:0] within_rev_pos, mid_rev_ref;
  int err_count, compares, n;
  shs_homing #(.CYC_PER_MS(10)) u_dut (.*);
  shs_axis_model u_axis (.*);
  initial begin
    forever #5 core_clk = !core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Preset the axis, then give a one-cycle start with the method set.
  task automatic go(input logic [3:0] m, input logic [31:0] pos);
    @(negedge core_clk) load = 1'b1;
    load_pos = pos;
    method = m;
    @(negedge core_clk) load = 1'b0;
    start = 1'b1;
    @(negedge core_clk) start = 1'b0;
  endtask
  task automatic wait_store(input int lim);
    n = 0;
    while (zero_position_write !== 1'b1 && n < lim) begin
      @(negedge core_clk);
      n++;
    end
    chk(zero_position_write, 1'b1);
  endtask
  task automatic home(input logic [3:0] m, input logic d, input logic p,
      input logic [31:0] pos, input logic [31:0] sh, input logic [31:0] e);
    direction = d;
    dog_polarity = p;
    zero_shift = sh;
    go(m, pos);
    wait_store(2000);
    chk(zero_position_data, e);
    chk(zeroing_complete, 1'b1);
  endtask
  task automatic t_dog;
    home(SHS_METHOD_DOG, 1'b0, 1'b0, 32'h0, 32'h0, 32'h1c0);
    // The axis stops one count past the Z mark at 0x1c0.
    chk(32'(within_rev_pos), 32'h1);
    home(SHS_METHOD_DOG, 1'b1, 1'b1, 32'h258, 32'ha, 32'hb6);
    chk(move_decrease, 1'b1);
    home(SHS_METHOD_COUNT, 1'b0, 1'b1, 32'h0, 32'h0, 32'h140);
    $display("dog and count homing done");
  endtask
  task automatic t_data;
    go(SHS_METHOD_DATA, 32'h1234);
    wait_store(20);
    chk(n, 1);
    chk(zero_position_data, 32'h1234);
    $display("data setting done");
  endtask
  task automatic t_stop;
    go(SHS_METHOD_STOPPER, 32'h77);
    chk(torque_limit_on, 1'b1);
    chk(torque_limit_out, stopper_torque);
    chk(accel_tc_out, accel_tc_pt1);
    // A broken contact must restart the dwell from zero.
    stopper_contact = 1'b1;
    repeat (15) @(negedge core_clk);
    stopper_contact = 1'b0;
    @(negedge core_clk) stopper_contact = 1'b1;
    wait_store(60);
    chk(n >= 20 && n <= 23, 1'b1);
    stopper_contact = 1'b0;
    $display("stopper done");
  endtask
  task automatic t_servo;
    @(negedge core_clk) load = 1'b1;
    load_pos = 32'h5a5;
    method = SHS_METHOD_SERVO_ON;
    @(negedge core_clk) load = 1'b0;
    servo_on = 1'b1;
    @(negedge core_clk);
    chk(move_enable, 1'b0);
    wait_store(20);
    chk(zero_position_data, 32'h5a5);
    servo_on = 1'b0;
    $display("servo-on home done");
  endtask
  task automatic t_refuse;
    auto_manual_select = 1'b1;
    go(SHS_METHOD_DATA, 32'h9);
    chk(zeroing_busy, 1'b0);
    auto_manual_select = 1'b0;
    go(4'h5, 32'h9);
    chk(method_error, 1'b1);
    motor_2000rpm = 1'b1;
    repeat (2) @(negedge core_clk);
    chk(mid_rev_ref, 14'h2000);
    $display("refusals done");
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    t_dog;
    t_data;
    t_stop;
    t_servo;
    t_refuse;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    close_out;
  end
endmodule // shs_homing_test
bind shs_homing shs_homing_chk u_chk (.*);
